// ---- pkg/dpsm_pkg.sv ----
// Constants and types for the dual-port memory host controller.
// Assumes a 20 MHz system clock and one port of the shared memory device outside.
package dpsm_pkg;
    // ==========================================================
    // Widths and mailbox addresses
    localparam int          ADDR_W        = 14;
    localparam int          DATA_W        = 16;
    localparam logic [13:0] MBOX_LEFT_ADR = 14'h3FFE;
    localparam logic [13:0] MBOX_RGHT_ADR = 14'h3FFF;
    localparam logic [15:0] FLAG_TAKE     = 16'h0000;
    localparam logic [15:0] FLAG_GIVE     = 16'h0001;
    // ==========================================================
    // Timing: each phase of an access lasts at least one 50 ns cycle
    localparam int          CLK_NS        = 50;
    localparam int          ACCESS_NS     = 20;
    localparam int          ACCESS_CYC    = ((ACCESS_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
                                            (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0]  ACCESS_CNT    = 4'(ACCESS_CYC);
    // ==========================================================
    // Command codes and states
    typedef enum logic [1:0] {DPSM_RD, DPSM_WR, DPSM_FRD, DPSM_FWR} dpsm_cmd_t;
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_DONE} dpsm_state_t;
endpackage

// ---- pkg/dpsm_pin_if.sv ----
// Pin-side bundle between the controller core and its pin driver.
// Assumes both ends share i_clock.
`timescale 1ns/100ps
interface dpsm_pin_if;
    logic        port_select_n;
    logic        flag_space_select_n;
    logic        read_write_n;
    logic        output_gate_n;
    logic        upper_lane_en_n;
    logic        lower_lane_en_n;
    logic [13:0] addr;
    logic [15:0] wdata;
    logic        drive;
    logic [15:0] rdata_sync;
    logic        wait_n_sync;
    modport core (output port_select_n, flag_space_select_n, read_write_n, output_gate_n,
                  upper_lane_en_n, lower_lane_en_n, addr, wdata, drive,
                  input rdata_sync, wait_n_sync);
    modport pins (input port_select_n, flag_space_select_n, read_write_n, output_gate_n,
                  upper_lane_en_n, lower_lane_en_n, addr, wdata, drive,
                  output rdata_sync, wait_n_sync);
endinterface

// ---- logic/dpsm_pin_sync.sv ----
// Pin stage: synchronises data and wait inputs; data outputs leave the host's flops directly.
// Assumes pins are asynchronous to i_clock.
`timescale 1ns/100ps
module dpsm_pin_sync (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    // Pins
    input  wire logic [15:0] i_data_in,
    input  wire logic        i_wait_n,
    dpsm_pin_if.pins         pin
);
    logic [15:0] data_s1_reg, data_s2_reg;
    logic        wait_s1_reg, wait_s2_reg;
    logic [15:0] data_s1_next, data_s2_next;
    logic        wait_s1_next, wait_s2_next;

    // ==========================================================
    // Two-flop synchronisers; first stage feeds only the second
    always_comb begin
        data_s1_next = i_data_in;
        data_s2_next = data_s1_reg;
        wait_s1_next = i_wait_n;
        wait_s2_next = wait_s1_reg;
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            data_s1_reg <= 16'h0000;
            data_s2_reg <= 16'h0000;
            wait_s1_reg <= 1'b1;
            wait_s2_reg <= 1'b1;
        end else begin
            data_s1_reg <= data_s1_next;
            data_s2_reg <= data_s2_next;
            wait_s1_reg <= wait_s1_next;
            wait_s2_reg <= wait_s2_next;
        end
    end

    assign pin.rdata_sync  = data_s2_reg;
    assign pin.wait_n_sync = wait_s2_reg;
endmodule

// ---- logic/dpsm_host.sv ----
// Host controller driving one port of the shared dual-port memory.
// Assumes a user issues one command at a time and the device sits on the pins.
// Behaviour
// - Read_write_n stays high through every array or flag read.
// - Address changes only while read_write_n is high.
// - Port select stays high across flag write then flag read.
// - Slave mode wait input holds off the port's write.
// - Host never drives data while the device drives it.
// - Select combination stays stable for the write window.
`timescale 1ns/100ps
module dpsm_host (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    // User command port
    input  wire logic        i_req_valid,
    output logic             o_req_ready,
    input  wire logic [1:0]  i_req_cmd,
    input  wire logic [13:0] i_req_addr,
    input  wire logic [15:0] i_req_wdata,
    input  wire logic [1:0]  i_req_lanes,
    output logic             o_rsp_valid,
    output logic [15:0]      o_rsp_rdata,
    output logic             o_flag_owned,
    // Device pins
    output logic             o_port_select_n,
    output logic             o_flag_space_select_n,
    output logic             o_read_write_n,
    output logic             o_output_gate_n,
    output logic             o_upper_lane_en_n,
    output logic             o_lower_lane_en_n,
    output logic [13:0]      o_addr,
    input  wire logic [15:0] i_data_in,
    output logic [15:0]      o_data_out,
    output logic [15:0]      o_data_oe,
    input  wire logic        i_wait_n,
    input  wire logic        i_mbox_alert_n
);
    dpsm_pin_if pin ();

    dpsm_pin_sync u_sync (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_data_in (i_data_in),
        .i_wait_n  (i_wait_n),
        .pin       (pin)
    );

    dpsm_pkg::dpsm_state_t state_reg, state_next;
    dpsm_pkg::dpsm_cmd_t   cmd_reg, cmd_next;
    logic [13:0] addr_reg, addr_next;
    logic [15:0] wdata_reg, wdata_next;
    logic [1:0]  lanes_reg, lanes_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        rsp_reg, rsp_next;
    logic        owned_reg, owned_next;
    logic        cs_n_reg, cs_n_next;
    logic        sem_n_reg, sem_n_next;
    logic        rw_n_reg, rw_n_next;
    logic        oe_n_reg, oe_n_next;
    logic        ub_n_reg, ub_n_next;
    logic        lb_n_reg, lb_n_next;
    logic        drv_reg, drv_next;

    // Write commands need the wait input released before strobing
    function automatic logic is_write(input dpsm_pkg::dpsm_cmd_t c);
        return (c == dpsm_pkg::DPSM_WR) || (c == dpsm_pkg::DPSM_FWR);
    endfunction

    function automatic logic is_flag(input dpsm_pkg::dpsm_cmd_t c);
        return (c == dpsm_pkg::DPSM_FRD) || (c == dpsm_pkg::DPSM_FWR);
    endfunction

    // Alert input is left for the user to poll; nothing here acts on it
    assign o_req_ready = (state_reg == dpsm_pkg::ST_IDLE);

    // ==========================================================
    // Access sequencer: setup, strobe, hold, done
    always_comb begin
        state_next = state_reg;
        cmd_next   = cmd_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        lanes_next = lanes_reg;
        cnt_next   = cnt_reg;
        rdata_next = rdata_reg;
        rsp_next   = 1'b0;
        owned_next = owned_reg;
        cs_n_next  = cs_n_reg;
        sem_n_next = sem_n_reg;
        rw_n_next  = rw_n_reg;
        oe_n_next  = oe_n_reg;
        ub_n_next  = ub_n_reg;
        lb_n_next  = lb_n_reg;
        drv_next   = drv_reg;
        unique case (state_reg)
            dpsm_pkg::ST_IDLE: begin
                if (i_req_valid) begin
                    // address moves only with read_write_n high
                    cmd_next   = dpsm_pkg::dpsm_cmd_t'(i_req_cmd);
                    addr_next  = i_req_addr;
                    wdata_next = i_req_wdata;
                    lanes_next = i_req_lanes;
                    rw_n_next  = 1'b1;
                    state_next = dpsm_pkg::ST_SETUP;
                end
            end
            dpsm_pkg::ST_SETUP: begin
                // hold off a write while the wait input is low
                if (!(is_write(cmd_reg) && !pin.wait_n_sync)) begin
                    // flag accesses keep port select high
                    // array and flag selects never low together
                    cs_n_next  = is_flag(cmd_reg);
                    sem_n_next = !is_flag(cmd_reg);
                    // flag reads use both lanes disabled
                    ub_n_next  = is_flag(cmd_reg) ? 1'b1 : !lanes_reg[1];
                    lb_n_next  = is_flag(cmd_reg) ? 1'b1 : !lanes_reg[0];
                    rw_n_next  = 1'b1;
                    // reads keep read_write_n high and open the output gate
                    oe_n_next  = is_write(cmd_reg);
                    cnt_next   = dpsm_pkg::ACCESS_CNT;
                    state_next = dpsm_pkg::ST_STROBE;
                end
            end
            dpsm_pkg::ST_STROBE: begin
                // write overlap, drive data only on writes
                rw_n_next = !is_write(cmd_reg);
                drv_next  = is_write(cmd_reg);
                // selects stay unchanged for the strobe window
                if (cnt_reg > 4'h1) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    cnt_next   = dpsm_pkg::ACCESS_CNT + 4'h1;
                    state_next = dpsm_pkg::ST_HOLD;
                end
            end
            dpsm_pkg::ST_HOLD: begin
                // End write with read_write_n, then data sampling after sync delay
                rw_n_next = 1'b1;
                if (cnt_reg > 4'h1) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    rdata_next = pin.rdata_sync;
                    state_next = dpsm_pkg::ST_DONE;
                end
            end
            dpsm_pkg::ST_DONE: begin
                drv_next   = 1'b0;
                cs_n_next  = 1'b1;
                sem_n_next = 1'b1;
                oe_n_next  = 1'b1;
                ub_n_next  = 1'b1;
                lb_n_next  = 1'b1;
                rsp_next   = 1'b1;
                // token is ours when the flag reads 0
                if (cmd_reg == dpsm_pkg::DPSM_FRD) begin
                    owned_next = !rdata_reg[0];
                end
                state_next = dpsm_pkg::ST_IDLE;
            end
        endcase
    end

    // Registers only
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= dpsm_pkg::ST_IDLE;
            cmd_reg   <= dpsm_pkg::DPSM_RD;
            addr_reg  <= 14'h0000;
            wdata_reg <= 16'h0000;
            lanes_reg <= 2'h0;
            cnt_reg   <= 4'h0;
            rdata_reg <= 16'h0000;
            rsp_reg   <= 1'b0;
            owned_reg <= 1'b0;
            cs_n_reg  <= 1'b1;
            sem_n_reg <= 1'b1;
            rw_n_reg  <= 1'b1;
            oe_n_reg  <= 1'b1;
            ub_n_reg  <= 1'b1;
            lb_n_reg  <= 1'b1;
            drv_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmd_reg   <= cmd_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            lanes_reg <= lanes_next;
            cnt_reg   <= cnt_next;
            rdata_reg <= rdata_next;
            rsp_reg   <= rsp_next;
            owned_reg <= owned_next;
            cs_n_reg  <= cs_n_next;
            sem_n_reg <= sem_n_next;
            rw_n_reg  <= rw_n_next;
            oe_n_reg  <= oe_n_next;
            ub_n_reg  <= ub_n_next;
            lb_n_reg  <= lb_n_next;
            drv_reg   <= drv_next;
        end
    end

    // ==========================================================
    // Pin outputs straight from flops
    assign o_port_select_n       = cs_n_reg;
    assign o_flag_space_select_n = sem_n_reg;
    assign o_read_write_n        = rw_n_reg;
    assign o_output_gate_n       = oe_n_reg;
    assign o_upper_lane_en_n     = ub_n_reg;
    assign o_lower_lane_en_n     = lb_n_reg;
    assign o_addr                = addr_reg;
    assign o_data_out            = wdata_reg;
    assign o_data_oe             = {dpsm_pkg::DATA_W{drv_reg}};
    assign o_rsp_valid           = rsp_reg;
    assign o_rsp_rdata           = rdata_reg;
    assign o_flag_owned          = owned_reg;
    assign pin.port_select_n       = cs_n_reg;
    assign pin.flag_space_select_n = sem_n_reg;
    assign pin.read_write_n        = rw_n_reg;
    assign pin.output_gate_n       = oe_n_reg;
    assign pin.upper_lane_en_n     = ub_n_reg;
    assign pin.lower_lane_en_n     = lb_n_reg;
    assign pin.addr                = addr_reg;
    assign pin.wdata               = wdata_reg;
    assign pin.drive               = drv_reg;

    // ==========================================================
    // Checks on the host's own pin discipline
    // reads never pull read_write_n low
    property p_read_rw_high;
        @(posedge i_clock) disable iff (i_sys_rst)
        (state_reg != dpsm_pkg::ST_IDLE && !is_write(cmd_reg)) |-> rw_n_reg;
    endproperty
    a_read_rw_high: assert property (p_read_rw_high) else $error("read strobed write");

    property p_addr_stable;
        @(posedge i_clock) disable iff (i_sys_rst)
        !rw_n_reg |=> $stable(addr_reg);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in write");

    property p_no_dual_sel;
        @(posedge i_clock) disable iff (i_sys_rst)
        !(!cs_n_reg && !sem_n_reg);
    endproperty
    a_no_dual_sel: assert property (p_no_dual_sel) else $error("both selects low");

    property p_no_drive_read;
        @(posedge i_clock) disable iff (i_sys_rst)
        !oe_n_reg |-> !drv_reg;
    endproperty
    a_no_drive_read: assert property (p_no_drive_read) else $error("drive during read");

    property p_flag_cs_high;
        @(posedge i_clock) disable iff (i_sys_rst)
        !sem_n_reg |-> cs_n_reg && ub_n_reg && lb_n_reg;
    endproperty
    a_flag_cs_high: assert property (p_flag_cs_high) else $error("flag access with cs");

    property p_wait_blocks;
        @(posedge i_clock) disable iff (i_sys_rst)
        (state_reg == dpsm_pkg::ST_SETUP && is_write(cmd_reg) && !pin.wait_n_sync)
            |=> state_reg == dpsm_pkg::ST_SETUP;
    endproperty
    a_wait_blocks: assert property (p_wait_blocks) else $error("write past wait");

    property p_sel_stable;
        @(posedge i_clock) disable iff (i_sys_rst)
        !rw_n_reg |=> $stable(cs_n_reg) && $stable(sem_n_reg);
    endproperty
    a_sel_stable: assert property (p_sel_stable) else $error("select moved in write");

    property p_sel_before_wr;
        @(posedge i_clock) disable iff (i_sys_rst)
        $fell(rw_n_reg) |-> $past(!cs_n_reg || !sem_n_reg);
    endproperty
    a_sel_before_wr: assert property (p_sel_before_wr) else $error("select after write");

    // data driven only by write commands
    property p_drive_write_only;
        @(posedge i_clock) disable iff (i_sys_rst)
        drv_reg |-> is_write(cmd_reg);
    endproperty
    a_drive_write_only: assert property (p_drive_write_only) else $error("drive on read");
endmodule

// ---- tb/dpsm_dev_model.sv ----
// Behavioural model of one port of the shared dual-port memory device.
// Assumes strobes come from the host; the far port is worked by bench tasks.
`timescale 1ns/100ps
module dpsm_dev_model (
    // Host strobes and bus
    input  wire logic        i_port_select_n,
    input  wire logic        i_flag_space_select_n,
    input  wire logic        i_read_write_n,
    input  wire logic        i_output_gate_n,
    input  wire logic        i_upper_lane_en_n,
    input  wire logic        i_lower_lane_en_n,
    input  wire logic [13:0] i_addr,
    input  wire logic [15:0] i_host_data,
    // Collision hold ordered by the bench
    input  wire logic        i_hold,
    // Device outputs
    output logic [15:0]      o_data,
    output logic             o_wait_n,
    output logic             o_mbox_alert_n
);
    // ==========================================================
    // State: owner 0 free, 1 this port, 2 far port
    logic [15:0] mem [0:16383];
    logic [15:0] junk        = 16'h5A5A;
    logic [1:0]  owner       = 2'h0;
    logic [2:1]  pend        = 2'b00;
    logic        far_alert_n = 1'b1;
    logic        wbit;
    logic        no_lane, arr_wr, flag_wr, arr_rd, flag_rd;
    // Released lines toggle so a stale value never passes for data
    initial forever #25 junk = ~junk;
    initial o_mbox_alert_n = 1'b1;
    // wait held low on this port as the losing side
    assign o_wait_n = !i_hold;
    assign no_lane = i_upper_lane_en_n && i_lower_lane_en_n;
    assign arr_wr  = !i_port_select_n && i_flag_space_select_n && !i_read_write_n && !no_lane;
    assign flag_wr = !i_flag_space_select_n && !i_read_write_n && (i_port_select_n || no_lane);
    assign arr_rd  = !i_port_select_n && i_flag_space_select_n && i_read_write_n
                     && !i_output_gate_n && !no_lane;
    assign flag_rd = !i_flag_space_select_n && i_read_write_n && !i_output_gate_n
                     && (i_port_select_n || no_lane);
    always @* begin
        o_data = junk;
        if (flag_rd)
            o_data = {16{owner != 2'h1}};
        if (arr_rd && !i_upper_lane_en_n)
            o_data[15:8] = mem[i_addr][15:8];
        if (arr_rd && !i_lower_lane_en_n)
            o_data[7:0] = mem[i_addr][7:0];
    end
    always @* begin
        if (arr_wr && !i_upper_lane_en_n)
            mem[i_addr][15:8] = i_host_data[15:8];
        if (arr_wr && !i_lower_lane_en_n)
            mem[i_addr][7:0] = i_host_data[7:0];
        if (flag_wr)
            wbit = i_host_data[0];
    end
    always @(posedge arr_wr)
        if (i_addr == 14'h3FFF)
            far_alert_n = 1'b0;
    always @(posedge arr_rd)
        if (i_addr == 14'h3FFE)
            o_mbox_alert_n = 1'b1;
    // token update; calls serialise so one port wins
    task automatic flag_write(input logic [1:0] me, input logic b);
        if (b === 1'b0 && owner == 2'h0)
            owner = me;
        else if (b === 1'b0 && owner != me)
            pend[me] = 1'b1;
        else if (b === 1'b1 && owner == me) begin
            owner = pend[3 - me] ? 2'(3 - me) : 2'h0;
            pend  = 2'b00;
        end
    endtask
    // Token moves as the write ends; an unknown bit at power-up does nothing
    always @(negedge flag_wr)
        flag_write(2'h1, wbit);
    // Far port actions
    task automatic far_flag(input logic b);
        flag_write(2'h2, b);
    endtask
    task automatic far_post();
        o_mbox_alert_n = 1'b0;
    endtask
endmodule

// ---- tb/dual_port_ram_semaphore_mailbox_tb.sv ----
// Self-checking bench for the dual-port memory host controller.
// Assumes the device model stands on the pins and plays the far port.
`timescale 1ns/100ps
module dual_port_ram_semaphore_mailbox_tb;
    // ==========================================================
    // Signals
    logic        i_clock, i_sys_rst, i_req_valid, o_req_ready, o_rsp_valid, o_flag_owned;
    logic [1:0]  i_req_cmd, i_req_lanes;
    logic [13:0] i_req_addr, o_addr, last_addr;
    logic [15:0] i_req_wdata, o_rsp_rdata, i_data_in, o_data_out, o_data_oe, bus_wr;
    logic        o_port_select_n, o_flag_space_select_n, o_read_write_n, o_output_gate_n;
    logic        o_upper_lane_en_n, o_lower_lane_en_n, i_wait_n, i_mbox_alert_n, hold;
    int          n_errors    = 0;
    int          comparisons = 0;
    dpsm_host DUT (
        .i_clock, .i_sys_rst, .i_req_valid, .o_req_ready, .i_req_cmd, .i_req_addr,
        .i_req_wdata, .i_req_lanes, .o_rsp_valid, .o_rsp_rdata, .o_flag_owned,
        .o_port_select_n, .o_flag_space_select_n, .o_read_write_n, .o_output_gate_n,
        .o_upper_lane_en_n, .o_lower_lane_en_n, .o_addr, .i_data_in, .o_data_out,
        .o_data_oe, .i_wait_n, .i_mbox_alert_n
    );
    // Only enabled host bits reach the device
    assign bus_wr = o_data_out & o_data_oe;
    dpsm_dev_model u_dev (
        .i_port_select_n(o_port_select_n), .i_flag_space_select_n(o_flag_space_select_n),
        .i_read_write_n(o_read_write_n), .i_output_gate_n(o_output_gate_n),
        .i_upper_lane_en_n(o_upper_lane_en_n), .i_lower_lane_en_n(o_lower_lane_en_n),
        .i_addr(o_addr), .i_host_data(bus_wr), .i_hold(hold), .o_data(i_data_in),
        .o_wait_n(i_wait_n), .o_mbox_alert_n(i_mbox_alert_n)
    );
    // ==========================================================
    // Clock, compare tasks and closing
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge i_clock) begin
        if (!i_sys_rst && ((!o_read_write_n && o_addr !== last_addr)
            || (!o_port_select_n && !o_flag_space_select_n
                && !(o_upper_lane_en_n && o_lower_lane_en_n))
            || (o_read_write_n && !o_output_gate_n && o_data_oe !== 16'h0000))) begin
            n_errors++;
            $display("ERROR t=%0t addr=%h last=%h", $time, o_addr, last_addr);
        end
        last_addr <= o_addr;
    end
    // One user command, held for one clock, then wait up to 60 cycles for its answer
    task automatic do_cmd(input logic [1:0] c, input logic [13:0] a, input logic [15:0] d,
                          input logic [1:0] lanes, output logic [15:0] q);
        int n;
        @(negedge i_clock);
        i_req_valid = 1'b1;
        i_req_cmd   = c;
        i_req_addr  = a;
        i_req_wdata = d;
        i_req_lanes = lanes;
        @(negedge i_clock);
        i_req_valid = 1'b0;
        for (n = 0; n < 60 && o_rsp_valid !== 1'b1; n++)
            @(negedge i_clock);
        check_bit(o_rsp_valid, 1'b1);
        q = o_rsp_rdata;
    endtask
    // Flag read of the host port with ownership flag
    task automatic host_flag(input logic exp);
        logic [15:0] q;
        do_cmd(dpsm_pkg::DPSM_FRD, 14'h0000, 16'h0000, 2'b00, q);
        check_bit(q[0], exp);
        check_bit(o_flag_owned, !exp);
    endtask
    task automatic flag_wr(input logic [15:0] d);
        logic [15:0] q;
        do_cmd(dpsm_pkg::DPSM_FWR, 14'h0000, d, 2'b00, q);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        repeat (20) @(negedge i_clock);
        check({10'h000, o_port_select_n, o_flag_space_select_n, o_read_write_n,
               o_output_gate_n, o_upper_lane_en_n, o_lower_lane_en_n}, 16'h003F);
        check(o_data_oe, 16'h0000);
        check_bit(o_req_ready, 1'b1);
        i_sys_rst = 1'b0;
    endtask
    task automatic t_array();
        logic [15:0] q;
        do_cmd(dpsm_pkg::DPSM_WR, 14'h0005, 16'hA5C3, 2'b11, q);
        do_cmd(dpsm_pkg::DPSM_WR, 14'h0006, 16'h1234, 2'b11, q);
        do_cmd(dpsm_pkg::DPSM_WR, 14'h0005, 16'h7E00, 2'b10, q);
        do_cmd(dpsm_pkg::DPSM_WR, 14'h0006, 16'hFF81, 2'b01, q);
        do_cmd(dpsm_pkg::DPSM_RD, 14'h0005, 16'h0000, 2'b11, q);
        check(q, 16'h7EC3);
        do_cmd(dpsm_pkg::DPSM_RD, 14'h0006, 16'h0000, 2'b11, q);
        check(q, 16'h1281);
        do_cmd(dpsm_pkg::DPSM_RD, 14'h0005, 16'h0000, 2'b01, q);
        check(q & 16'h00FF, 16'h00C3);
    endtask
    task automatic t_flag();
        host_flag(1'b1);
        flag_wr(dpsm_pkg::FLAG_TAKE);
        host_flag(1'b0);
        check_bit(u_dev.owner != 2'h2, 1'b1);
        u_dev.far_flag(1'b0);
        host_flag(1'b0);
        flag_wr(dpsm_pkg::FLAG_GIVE);
        host_flag(1'b1);
        check_bit(u_dev.owner != 2'h2, 1'b0);
        flag_wr(dpsm_pkg::FLAG_TAKE);
        host_flag(1'b1);
        u_dev.far_flag(1'b1);
        host_flag(1'b0);
        flag_wr(dpsm_pkg::FLAG_GIVE);
        host_flag(1'b1);
        check_bit(u_dev.owner != 2'h2, 1'b1);
        flag_wr(dpsm_pkg::FLAG_GIVE);
        host_flag(1'b1);
    endtask
    task automatic t_mbox();
        logic [15:0] q;
        u_dev.far_post();
        do_cmd(dpsm_pkg::DPSM_RD, 14'h3FFD, 16'h0000, 2'b11, q);
        check_bit(i_mbox_alert_n, 1'b0);
        do_cmd(dpsm_pkg::DPSM_RD, dpsm_pkg::MBOX_LEFT_ADR, 16'h0000, 2'b11, q);
        check_bit(i_mbox_alert_n, 1'b1);
        do_cmd(dpsm_pkg::DPSM_WR, dpsm_pkg::MBOX_RGHT_ADR, 16'h00C5, 2'b11, q);
        check_bit(u_dev.far_alert_n, 1'b0);
    endtask
    task automatic t_hold();
        logic [15:0] q;
        hold = 1'b1;
        repeat (4) @(negedge i_clock);
        fork
            do_cmd(dpsm_pkg::DPSM_WR, 14'h0100, 16'hBEEF, 2'b11, q);
            begin
                repeat (20) begin
                    @(negedge i_clock);
                    check_bit(o_read_write_n, 1'b1);
                end
                hold = 1'b0;
            end
        join
        do_cmd(dpsm_pkg::DPSM_RD, 14'h0100, 16'h0000, 2'b11, q);
        check(q, 16'hBEEF);
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        i_sys_rst   = 1'b1;
        i_req_valid = 1'b0;
        i_req_cmd   = 2'h0;
        i_req_addr  = 14'h0000;
        i_req_wdata = 16'h0000;
        i_req_lanes = 2'h0;
        hold        = 1'b0;
        t_reset();
        t_array();
        t_flag();
        t_mbox();
        t_hold();
        wrap_up();
    end
    initial begin
        #(50 * 20000);
        n_errors++;
        wrap_up();
    end
endmodule
